// ==== logic/irq_ctrl_pkg.sv ====
package irq_ctrl_pkg;
	localparam int unsigned PC_W = 13;
	localparam int unsigned NUM_SRC = 8;
	localparam int unsigned SRC_IDX_W = 3;
	localparam int unsigned APB_AW = 12;
	// Register byte offsets on the bus
	localparam logic [APB_AW-1:0] OFS_EDGE = 12'h000;
	localparam logic [APB_AW-1:0] OFS_CTRL0 = 12'h004;
	localparam logic [APB_AW-1:0] OFS_CTRL1 = 12'h008;
	localparam logic [APB_AW-1:0] OFS_CTRL2 = 12'h00c;
	localparam logic [APB_AW-1:0] OFS_TMR0 = 12'h010;
	localparam logic [APB_AW-1:0] OFS_TMR1 = 12'h014;
	localparam logic [APB_AW-1:0] OFS_STACK = 12'h018;
	// Source slots, also the index into the vector table
	localparam logic [2:0] SRC_EXT = 3'h0;
	localparam logic [2:0] SRC_TOUCH = 3'h1;
	localparam logic [2:0] SRC_MF0 = 3'h2;
	localparam logic [2:0] SRC_SER = 3'h3;
	localparam logic [2:0] SRC_TB0 = 3'h4;
	localparam logic [2:0] SRC_TB1 = 3'h5;
	localparam logic [2:0] SRC_EE = 3'h6;
	localparam logic [2:0] SRC_MF1 = 3'h7;
	// Bit positions inside the control registers
	localparam int unsigned B_EMI = 0;
	localparam int unsigned B_LO_EN = 1;
	localparam int unsigned B_HI_EN = 2;
	localparam int unsigned B_TOP_EN = 3;
	localparam int unsigned B_BASE_F = 4;
	localparam int unsigned B_LO_F = 5;
	localparam int unsigned B_HI_F = 6;
	localparam int unsigned B_TOP_F = 7;
	localparam int unsigned B_TM_PE = 0;
	localparam int unsigned B_TM_AE = 1;
	localparam int unsigned B_TM_PF = 4;
	localparam int unsigned B_TM_AF = 5;
	// Edge select encodings
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Field k of the priority word names the source at rank k (rank 0 first)
	localparam logic [NUM_SRC*SRC_IDX_W-1:0] PRIO_DEFAULT = 24'hfa_c688;
	localparam logic [NUM_SRC*PC_W-1:0] VEC_DEFAULT = {13'h0020, 13'h001c, 13'h0018,
		13'h0014, 13'h0010, 13'h000c, 13'h0008, 13'h0004};

	typedef struct packed {
		logic touch_ovf;
		logic [1:0] tick_ovf;
		logic eeprom_done;
		logic uart_mode;
		logic [3:0] sync_evt;
		logic [5:0] uart_evt;
		logic [1:0] cmp_a;
		logic [1:0] cmp_p;
	} periph_evt_s;

	typedef struct packed {
		logic instr_end;
		logic call;
		logic ret;
		logic return_from_interrupt;
		logic [PC_W-1:0] next_pc;
	} cpu_req_s;
endpackage

// ==== logic/irq_ctrl.sv ====
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/100ps
module irq_ctrl import irq_ctrl_pkg::*; #(
	parameter int unsigned STACK_DEPTH = 8,
	parameter logic [NUM_SRC*SRC_IDX_W-1:0] PRIORITY = PRIO_DEFAULT,
	parameter logic [NUM_SRC*PC_W-1:0] VECTORS = VEC_DEFAULT
) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [APB_AW-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic EXT_PIN,
	input wire logic EXT_PIN_ROUTED,
	input wire logic EXT_PIN_IS_INPUT,
	input wire periph_evt_s PERIPH_EVT,
	input wire logic SLEEP_MODE,
	input wire cpu_req_s CPU_REQ,
	output logic PC_LOAD,
	output logic [PC_W-1:0] PC_VALUE,
	output logic IRQ_TAKEN,
	output logic [SRC_IDX_W-1:0] IRQ_SRC,
	output logic STACK_FULL,
	output logic WAKE
);
	localparam int unsigned SP_W = $clog2(STACK_DEPTH + 1);
	localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);

	typedef struct packed {
		logic [1:0] edge_sel;
		logic global_irq_enable;
		logic [NUM_SRC-1:0] src_en;
		logic [NUM_SRC-1:0] src_flag;
		logic [3:0] tm_en;
		logic [3:0] tm_flag;
		logic pin_prev;
		logic pin_ok_prev;
		logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
		logic [SP_W-1:0] sp;
		logic full;
		logic pc_load;
		logic [PC_W-1:0] pc_value;
		logic irq_taken;
		logic [SRC_IDX_W-1:0] irq_src;
		logic wake;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_s;

	state_s s;
	state_s next_s;
	logic setup;
	logic wr;
	logic mapped;
	logic take;
	logic found;
	logic [SRC_IDX_W-1:0] sel;
	logic [SRC_IDX_W-1:0] cand;
	logic [NUM_SRC-1:0] pend;
	logic [7:0] rd;
	logic pin_ok;
	logic rise;
	logic fall;
	logic ext_evt;
	logic ser_evt;
	logic [3:0] tm_rise;

	// Decode and read mux; reserved bits read as zero
	always_comb begin
		rd = REG_RESET;
		mapped = 1'b1;
		if (PADDR == OFS_EDGE) begin
			rd[1:0] = s.edge_sel;
		end else if (PADDR == OFS_CTRL0) begin
			rd[B_EMI] = s.global_irq_enable;
			rd[B_LO_EN] = s.src_en[SRC_EXT];
			rd[B_HI_EN] = s.src_en[SRC_TOUCH];
			rd[B_TOP_EN] = s.src_en[SRC_MF0];
			rd[B_BASE_F] = s.src_flag[SRC_EXT];
			rd[B_LO_F] = s.src_flag[SRC_TOUCH];
			rd[B_HI_F] = s.src_flag[SRC_MF0];
		end else if (PADDR == OFS_CTRL1) begin
			rd[B_EMI] = s.src_en[SRC_SER];
			rd[B_LO_EN] = s.src_en[SRC_TB0];
			rd[B_HI_EN] = s.src_en[SRC_TB1];
			rd[B_TOP_EN] = s.src_en[SRC_EE];
			rd[B_BASE_F] = s.src_flag[SRC_SER];
			rd[B_LO_F] = s.src_flag[SRC_TB0];
			rd[B_HI_F] = s.src_flag[SRC_TB1];
			rd[B_TOP_F] = s.src_flag[SRC_EE];
		end else if (PADDR == OFS_CTRL2) begin
			rd[B_EMI] = s.src_en[SRC_MF1];
			rd[B_BASE_F] = s.src_flag[SRC_MF1];
		end else if (PADDR == OFS_TMR0) begin
			rd[B_TM_PE] = s.tm_en[0];
			rd[B_TM_AE] = s.tm_en[1];
			rd[B_TM_PF] = s.tm_flag[0];
			rd[B_TM_AF] = s.tm_flag[1];
		end else if (PADDR == OFS_TMR1) begin
			rd[B_TM_PE] = s.tm_en[2];
			rd[B_TM_AE] = s.tm_en[3];
			rd[B_TM_PF] = s.tm_flag[2];
			rd[B_TM_AF] = s.tm_flag[3];
		end else if (PADDR == OFS_STACK) begin
			rd[7] = s.full;
			rd[SP_W-1:0] = s.sp;
		end else begin
			mapped = 1'b0;
		end
	end

	// Fixed priority pick among enabled pending sources
	always_comb begin
		found = 1'b0;
		sel = SRC_EXT;
		cand = SRC_EXT;
		pend = s.src_flag & s.src_en;
		for (int k = 0; k < NUM_SRC; k++) begin
			cand = PRIORITY[k*SRC_IDX_W +: SRC_IDX_W];
			if (pend[cand] && !found) begin
				found = 1'b1;
				sel = cand;
			end
		end
		// Only at an instruction boundary with no stack op competing
		take = CPU_REQ.instr_end && !CPU_REQ.call && !CPU_REQ.ret && !CPU_REQ.return_from_interrupt
			&& s.global_irq_enable && !s.full && found;
	end

	// Peripheral event qualification
	always_comb begin
		pin_ok = EXT_PIN_ROUTED && EXT_PIN_IS_INPUT;
		rise = pin_ok && s.pin_ok_prev && EXT_PIN && !s.pin_prev;
		fall = pin_ok && s.pin_ok_prev && !EXT_PIN && s.pin_prev;
		ext_evt = ((s.edge_sel == EDGE_RISE) && rise) || ((s.edge_sel == EDGE_FALL) && fall)
			|| ((s.edge_sel == EDGE_BOTH) && (rise || fall));
		ser_evt = PERIPH_EVT.uart_mode ? |PERIPH_EVT.uart_evt : |PERIPH_EVT.sync_evt;
	end

	// Next state: bus write, then service clears, then hardware sets so a set wins
	always_comb begin
		next_s = s;
		next_s.pc_load = 1'b0;
		next_s.irq_taken = 1'b0;
		next_s.wake = 1'b0;
		tm_rise = 4'h0;
		setup = PSEL && !PENABLE;
		// Zero-wait slave: answer prepared in setup, presented in access
		next_s.pready = setup;
		next_s.pslverr = setup && !mapped;
		next_s.prdata = setup ? {24'h00_0000, rd} : 32'h0000_0000;
		wr = PSEL && PENABLE && s.pready && PWRITE && !s.pslverr;
		if (wr) begin
			if (PADDR == OFS_EDGE) begin
				next_s.edge_sel = PWDATA[1:0];
			end else if (PADDR == OFS_CTRL0) begin
				next_s.global_irq_enable = PWDATA[B_EMI];
				next_s.src_en[SRC_EXT] = PWDATA[B_LO_EN];
				next_s.src_en[SRC_TOUCH] = PWDATA[B_HI_EN];
				next_s.src_en[SRC_MF0] = PWDATA[B_TOP_EN];
				next_s.src_flag[SRC_EXT] = PWDATA[B_BASE_F];
				next_s.src_flag[SRC_TOUCH] = PWDATA[B_LO_F];
				next_s.src_flag[SRC_MF0] = PWDATA[B_HI_F];
			end else if (PADDR == OFS_CTRL1) begin
				next_s.src_en[SRC_SER] = PWDATA[B_EMI];
				next_s.src_en[SRC_TB0] = PWDATA[B_LO_EN];
				next_s.src_en[SRC_TB1] = PWDATA[B_HI_EN];
				next_s.src_en[SRC_EE] = PWDATA[B_TOP_EN];
				next_s.src_flag[SRC_SER] = PWDATA[B_BASE_F];
				next_s.src_flag[SRC_TB0] = PWDATA[B_LO_F];
				next_s.src_flag[SRC_TB1] = PWDATA[B_HI_F];
				next_s.src_flag[SRC_EE] = PWDATA[B_TOP_F];
			end else if (PADDR == OFS_CTRL2) begin
				next_s.src_en[SRC_MF1] = PWDATA[B_EMI];
				next_s.src_flag[SRC_MF1] = PWDATA[B_BASE_F];
			end else if (PADDR == OFS_TMR0) begin
				next_s.tm_en[1:0] = {PWDATA[B_TM_AE], PWDATA[B_TM_PE]};
				next_s.tm_flag[1:0] = {PWDATA[B_TM_AF], PWDATA[B_TM_PF]};
			end else if (PADDR == OFS_TMR1) begin
				next_s.tm_en[3:2] = {PWDATA[B_TM_AE], PWDATA[B_TM_PE]};
				next_s.tm_flag[3:2] = {PWDATA[B_TM_AF], PWDATA[B_TM_PF]};
			end
		end
		// Sequencer side: take, call push, or pop
		if (take) begin
			next_s.global_irq_enable = 1'b0;
			next_s.src_flag[sel] = 1'b0;
			next_s.stk[s.sp] = CPU_REQ.next_pc;
			next_s.sp = s.sp + 1'b1;
			next_s.pc_load = 1'b1;
			next_s.pc_value = VECTORS[sel*PC_W +: PC_W];
			next_s.irq_taken = 1'b1;
			next_s.irq_src = sel;
		end else if (CPU_REQ.call && !s.full) begin
			next_s.stk[s.sp] = CPU_REQ.next_pc;
			next_s.sp = s.sp + 1'b1;
		end else if ((CPU_REQ.ret || CPU_REQ.return_from_interrupt) && (s.sp != '0)) begin
			next_s.sp = s.sp - 1'b1;
			next_s.pc_load = 1'b1;
			next_s.pc_value = s.stk[s.sp - 1'b1];
			if (CPU_REQ.return_from_interrupt) begin
				next_s.global_irq_enable = 1'b1;
			end
		end
		// Hardware sets; blocked or disabled requests are kept
		next_s.tm_flag = next_s.tm_flag | {PERIPH_EVT.cmp_a[1], PERIPH_EVT.cmp_p[1],
			PERIPH_EVT.cmp_a[0], PERIPH_EVT.cmp_p[0]};
		// Group flag follows an enabled member becoming set, by hardware or write
		tm_rise = (next_s.tm_flag & next_s.tm_en) & ~(s.tm_flag & s.tm_en);
		next_s.src_flag[SRC_MF0] = next_s.src_flag[SRC_MF0] | (|tm_rise[1:0]);
		next_s.src_flag[SRC_MF1] = next_s.src_flag[SRC_MF1] | (|tm_rise[3:2]);
		next_s.src_flag[SRC_EXT] = next_s.src_flag[SRC_EXT] | ext_evt;
		next_s.src_flag[SRC_TOUCH] = next_s.src_flag[SRC_TOUCH] | PERIPH_EVT.touch_ovf;
		next_s.src_flag[SRC_TB0] = next_s.src_flag[SRC_TB0] | PERIPH_EVT.tick_ovf[0];
		next_s.src_flag[SRC_TB1] = next_s.src_flag[SRC_TB1] | PERIPH_EVT.tick_ovf[1];
		next_s.src_flag[SRC_EE] = next_s.src_flag[SRC_EE] | PERIPH_EVT.eeprom_done;
		next_s.src_flag[SRC_SER] = next_s.src_flag[SRC_SER] | ser_evt;
		// Wake only on a 0 to 1 change, so a pre-set flag masks its wake-up
		next_s.wake = SLEEP_MODE && (|({next_s.src_flag, next_s.tm_flag}
			& ~{s.src_flag, s.tm_flag}));
		next_s.full = (next_s.sp == SP_FULL);
		next_s.pin_prev = EXT_PIN;
		next_s.pin_ok_prev = pin_ok;
	end

	// Single state register
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign PRDATA = s.prdata;
	assign PREADY = s.pready;
	assign PSLVERR = s.pslverr;
	assign PC_LOAD = s.pc_load;
	assign PC_VALUE = s.pc_value;
	assign IRQ_TAKEN = s.irq_taken;
	assign IRQ_SRC = s.irq_src;
	assign STACK_FULL = s.full;
	assign WAKE = s.wake;

	// Checks on the design's own behaviour
	a_gie_blocks_take: assert property (@(posedge CLK) disable iff (!ARST_N)
		!s.global_irq_enable |=> !IRQ_TAKEN) else $error("interrupt taken with global enable low");
	a_full_blocks_take: assert property (@(posedge CLK) disable iff (!ARST_N)
		s.full |=> !IRQ_TAKEN) else $error("interrupt taken with stack full");
	a_take_clears_gie: assert property (@(posedge CLK) disable iff (!ARST_N)
		IRQ_TAKEN |-> !s.global_irq_enable && !s.src_en[IRQ_SRC] || !s.global_irq_enable)
		else $error("global enable still set after take");
	a_take_pushes_pc: assert property (@(posedge CLK) disable iff (!ARST_N)
		IRQ_TAKEN |-> s.sp == $past(s.sp) + 1'b1 && PC_LOAD
		&& PC_VALUE == VECTORS[IRQ_SRC*PC_W +: PC_W]
		&& s.stk[$past(s.sp)] == $past(CPU_REQ.next_pc))
		else $error("take did not push pc and load vector");
	a_return_from_interrupt_sets_gie: assert property (@(posedge CLK) disable iff (!ARST_N)
		CPU_REQ.return_from_interrupt && s.sp != '0 |=> s.global_irq_enable && PC_LOAD && s.sp == $past(s.sp) - 1'b1)
		else $error("return from interrupt did not restore");
	a_ret_keeps_gie: assert property (@(posedge CLK) disable iff (!ARST_N)
		CPU_REQ.ret && !CPU_REQ.return_from_interrupt && !wr |=> s.global_irq_enable == $past(s.global_irq_enable))
		else $error("plain return changed global enable");
	a_disabled_flag_held: assert property (@(posedge CLK) disable iff (!ARST_N)
		s.src_flag[SRC_EE] && !s.src_en[SRC_EE] && !wr |=> s.src_flag[SRC_EE])
		else $error("disabled pending flag was lost");
	a_group_keeps_members: assert property (@(posedge CLK) disable iff (!ARST_N)
		IRQ_TAKEN && IRQ_SRC == SRC_MF0 && !$past(wr)
		|-> ($past(s.tm_flag) & ~s.tm_flag) == 4'h0)
		else $error("group service cleared a member flag");
	a_wake_on_rise: assert property (@(posedge CLK) disable iff (!ARST_N)
		$rose(s.src_flag[SRC_EE]) && $past(SLEEP_MODE) |-> WAKE)
		else $error("flag rise in sleep gave no wake");
	a_edge_off_quiet: assert property (@(posedge CLK) disable iff (!ARST_N)
		s.edge_sel == EDGE_OFF && !wr |=> !$rose(s.src_flag[SRC_EXT]))
		else $error("external flag set with edges disabled");
	a_serial_sets: assert property (@(posedge CLK) disable iff (!ARST_N)
		ser_evt |=> s.src_flag[SRC_SER]) else $error("serial event lost");
	// A take must serve an enabled pending source, and rank 0 first when it waits
	a_take_needs_enable: assert property (@(posedge CLK) disable iff (!ARST_N)
		IRQ_TAKEN |-> IRQ_SRC == $past(sel) && $past(pend[sel]))
		else $error("take of a source that was not enabled and pending");
	a_prio_first: assert property (@(posedge CLK) disable iff (!ARST_N)
		IRQ_TAKEN && $past(pend[PRIORITY[SRC_IDX_W-1:0]])
		|-> IRQ_SRC == PRIORITY[SRC_IDX_W-1:0])
		else $error("top ranked source was passed over");
	// Serviced flags drop unless a fresh event lands in the take cycle, which wins
	a_ext_flag_clears: assert property (@(posedge CLK) disable iff (!ARST_N)
		IRQ_TAKEN && IRQ_SRC == SRC_EXT && !$past(ext_evt) |-> !s.src_flag[SRC_EXT])
		else $error("external flag kept after service");
	a_eeprom_clears: assert property (@(posedge CLK) disable iff (!ARST_N)
		IRQ_TAKEN && IRQ_SRC == SRC_EE && !$past(PERIPH_EVT.eeprom_done)
		|-> !s.src_flag[SRC_EE]) else $error("eeprom flag kept after service");
	a_serial_clears: assert property (@(posedge CLK) disable iff (!ARST_N)
		IRQ_TAKEN && IRQ_SRC == SRC_SER && !$past(ser_evt) |-> !s.src_flag[SRC_SER])
		else $error("serial flag kept after service");
	a_touch_clears: assert property (@(posedge CLK) disable iff (!ARST_N)
		IRQ_TAKEN && IRQ_SRC == SRC_TOUCH && !$past(PERIPH_EVT.touch_ovf)
		|-> !s.src_flag[SRC_TOUCH]) else $error("touch flag kept after service");
	// Pin gating, the edge select write, the group flag set and wake only in sleep
	a_pin_gated: assert property (@(posedge CLK) disable iff (!ARST_N)
		!pin_ok && !wr |=> !$rose(s.src_flag[SRC_EXT]))
		else $error("external flag set while pin not usable");
	a_edge_write_lands: assert property (@(posedge CLK) disable iff (!ARST_N)
		wr && PADDR == OFS_EDGE |=> s.edge_sel == $past(PWDATA[1:0]))
		else $error("edge select write did not land");
	a_group_sets: assert property (@(posedge CLK) disable iff (!ARST_N)
		|tm_rise[1:0] |=> s.src_flag[SRC_MF0]) else $error("group flag missed a member");
	a_wake_needs_sleep: assert property (@(posedge CLK) disable iff (!ARST_N)
		WAKE |-> $past(SLEEP_MODE)) else $error("wake pulse outside sleep");
endmodule

// ==== verif/cpu_seq_model.sv ====
`timescale 1ns/100ps
// Sequencer stand-in: sits at an instruction boundary and follows each PC load
module cpu_seq_model import irq_ctrl_pkg::*; (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic pc_load,
	input wire logic [PC_W-1:0] pc_value,
	output cpu_req_s cpu_req
);
	logic [2:0] op_q = 3'h0;
	logic [PC_W-1:0] next_pc = 13'h0abc;
	// Call, ret and return_from_interrupt last one cycle; a take is refused in that cycle.
	// No boundary while a PC load is consumed, else a take would push a stale address
	assign cpu_req = '{instr_end: !pc_load, call: op_q[2], ret: op_q[1], return_from_interrupt: op_q[0],
		next_pc: next_pc};
	// Fetch resumes at the vector or at the popped address
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			next_pc <= 13'h0abc;
		end else if (pc_load) begin
			next_pc <= pc_value;
		end
	end
	// One operation, changed only just after a rising edge
	task automatic op(input logic [2:0] code);
		@(posedge clk);
		op_q <= code;
		@(posedge clk);
		op_q <= 3'h0;
	endtask
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
module tb_top import irq_ctrl_pkg::*; ;
	localparam int LIMIT = 5000;
	logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pin = 1'b0, routed = 1'b1, isin = 1'b1, sleep = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	periph_evt_s evt = '0, v;
	cpu_req_s cpu_req;
	logic pready, pslverr, pc_load, taken, full, wake, err;
	logic [PC_W-1:0] pc_value, ret_pc, outer_pc;
	logic [SRC_IDX_W-1:0] src;
	int n_mismatch = 0, tests_run = 0, cycles = 0, n_take = 0, n_wake = 0, n0;
	typedef struct packed {logic [APB_AW-1:0] a; logic [31:0] w; logic [7:0] r; logic e;} row_s;
	// Last row is an unmapped word: refused, reads zero
	row_s rows[8] = '{'{OFS_EDGE, 32'hffff_ff03, 8'h03, 1'b0},
		'{OFS_CTRL0, 32'h0000_000e, 8'h0e, 1'b0}, '{OFS_CTRL1, 32'h0000_000f, 8'h0f, 1'b0},
		'{OFS_CTRL2, 32'h0000_0001, 8'h01, 1'b0}, '{OFS_TMR0, 32'h0000_0003, 8'h03, 1'b0},
		'{OFS_TMR1, 32'h0000_0003, 8'h03, 1'b0}, '{OFS_STACK, 32'h0000_00ff, 8'h00, 1'b0},
		'{12'h01c, 32'h0000_00ff, 8'h00, 1'b1}};
	logic [SRC_IDX_W-1:0] order[5] = '{SRC_TOUCH, SRC_SER, SRC_TB0, SRC_TB1, SRC_EE};

	always #4 clk = ~clk;

	irq_ctrl #(.STACK_DEPTH(2)) dut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .EXT_PIN(pin), .EXT_PIN_ROUTED(routed),
		.EXT_PIN_IS_INPUT(isin), .PERIPH_EVT(evt), .SLEEP_MODE(sleep), .CPU_REQ(cpu_req),
		.PC_LOAD(pc_load), .PC_VALUE(pc_value), .IRQ_TAKEN(taken), .IRQ_SRC(src),
		.STACK_FULL(full), .WAKE(wake));
	cpu_seq_model cpu (.clk(clk), .arst_n(arst_n), .pc_load(pc_load), .pc_value(pc_value),
		.cpu_req(cpu_req));

	// Count takes and wake pulses; a hang ends the run as a failure
	always @(posedge clk) begin
		cycles <= cycles + 1;
		n_take <= n_take + 32'(taken === 1'b1);
		n_wake <= n_wake + 32'(wake === 1'b1);
		if (cycles > LIMIT) begin
			n_mismatch++;
			final_report();
		end
	end

	task automatic final_report();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chkpc(input string name, input logic [PC_W-1:0] exp, got);
		chk(name, 32'(exp), 32'(got));
	endtask
	// Request held from setup until pready is sampled high
	task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] w);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= w;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [APB_AW-1:0] a, input logic [7:0] d);
		apb(1'b1, a, 32'(d));
	endtask
	task automatic rd8(input string name, input logic [APB_AW-1:0] a, input logic [7:0] exp);
		apb(1'b0, a, '0);
		chk(name, 32'(exp), rd);
	endtask
	// Wait bounded for a take (tk) or a return load, then check what came out
	task automatic wait_out(input logic tk, input logic [SRC_IDX_W-1:0] s);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while ((tk ? taken : pc_load) !== 1'b1 && k < 20);
		chk("strobe", 32'h0000_0001, 32'(tk ? taken : pc_load));
		if (tk) begin
			chk("irq_src", 32'(s), 32'(src));
			chkpc("vector", VEC_DEFAULT[s*PC_W +: PC_W], pc_value);
			ret_pc = cpu.next_pc;
		end else begin
			chkpc("return_pc", ret_pc, pc_value);
		end
	endtask
	// One-cycle event pulse; the mode level is kept afterwards
	task automatic pulse(input periph_evt_s p);
		@(posedge clk);
		evt <= p;
		@(posedge clk);
		evt <= '{uart_mode: p.uart_mode, default: '0};
	endtask

	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		// Reset value, write, read back, clear
		foreach (rows[i]) begin
			rd8("reset_val", rows[i].a, REG_RESET);
			chk("slverr", 32'(rows[i].e), 32'(err));
			apb(1'b1, rows[i].a, rows[i].w);
			rd8("readback", rows[i].a, rows[i].r);
			wr(rows[i].a, 8'h00);
		end
		// Edge select, direction and pin gating; global enable off
		for (int k = 0; k < 10; k++) begin
			routed <= (k != 8);
			isin <= (k != 9);
			pin <= k[0];
			repeat (3) @(posedge clk);
			wr(OFS_EDGE, k < 8 ? 8'(k >> 1) : 8'h03);
			wr(OFS_CTRL0, 8'h02);
			@(posedge clk);
			pin <= ~k[0];
			repeat (3) @(posedge clk);
			rd8("ext_flag", OFS_CTRL0, (k < 8 && (k >> 1 == 3 || k >> 1 == (k & 1) + 1)) ?
				8'h12 : 8'h02);
		end
		// External take and auto-clear; pin direction back to input first
		isin <= 1'b1;
		wr(OFS_EDGE, 8'h01);
		n0 = n_take;
		pin <= 1'b1;
		repeat (3) @(posedge clk);
		rd8("ext_pending", OFS_CTRL0, 8'h12);
		chk("no_take", 32'(n0), 32'(n_take));
		wr(OFS_CTRL0, 8'h13);
		wait_out(1'b1, SRC_EXT);
		rd8("ext_served", OFS_CTRL0, 8'h02);
		// Inside the routine: blocked request kept, software re-enables to nest
		wr(OFS_CTRL1, 8'h88);
		outer_pc = ret_pc;
		wr(OFS_CTRL0, 8'h03);
		wait_out(1'b1, SRC_EE);
		cpu.op(3'h1);
		wait_out(1'b0, '0);
		ret_pc = outer_pc;
		wr(OFS_CTRL1, 8'h00);
		cpu.op(3'h1);
		wait_out(1'b0, '0);
		rd8("return_from_interrupt_global", OFS_CTRL0, 8'h03);
		// Five pending at once, served in rank order
		wr(OFS_CTRL0, 8'h24);
		wr(OFS_CTRL1, 8'hff);
		wr(OFS_CTRL0, 8'h25);
		foreach (order[i]) begin
			wait_out(1'b1, order[i]);
			cpu.op(3'h1);
			wait_out(1'b0, '0);
		end
		rd8("flags_served", OFS_CTRL1, 8'h0f);
		rd8("touch_served", OFS_CTRL0, 8'h05);
		// Timer matches through both groups; A enable off gates its match
		for (int u = 0; u < 2; u++) begin
			wr(u ? OFS_TMR1 : OFS_TMR0, 8'h01);
			wr(OFS_CTRL2, 8'(u));
			wr(OFS_CTRL0, u ? 8'h01 : 8'h09);
			n0 = n_take;
			v = '0;
			v.cmp_a[u] = 1'b1;
			pulse(v);
			repeat (4) @(posedge clk);
			chk("a_gated", 32'(n0), 32'(n_take));
			v = '0;
			v.cmp_p[u] = 1'b1;
			pulse(v);
			wait_out(1'b1, u ? SRC_MF1 : SRC_MF0);
			rd8("timer_flags", u ? OFS_TMR1 : OFS_TMR0, 8'h31);
			rd8("group_served", u ? OFS_CTRL2 : OFS_CTRL0, u ? 8'h01 : 8'h08);
			cpu.op(3'h1);
			wait_out(1'b0, '0);
			wr(u ? OFS_TMR1 : OFS_TMR0, 8'h00);
		end
		wr(OFS_CTRL2, 8'h00);
		// Full stack holds off an enabled request until a pop
		ret_pc = cpu.next_pc;
		cpu.op(3'h4);
		cpu.op(3'h4);
		rd8("stack_full", OFS_STACK, 8'h82);
		chk("full_pin", 32'h0000_0001, 32'(full));
		wr(OFS_CTRL1, 8'h88);
		wr(OFS_CTRL0, 8'h01);
		n0 = n_take;
		repeat (5) @(posedge clk);
		chk("full_block", 32'(n0), 32'(n_take));
		cpu.op(3'h2);
		wait_out(1'b0, '0);
		wait_out(1'b1, SRC_EE);
		cpu.op(3'h1);
		wait_out(1'b0, '0);
		cpu.op(3'h2);
		wait_out(1'b0, '0);
		rd8("stack_empty", OFS_STACK, 8'h00);
		wr(OFS_CTRL0, 8'h00);
		wr(OFS_CTRL1, 8'h00);
		// Every serial event in its own mode
		for (int k = 0; k < 10; k++) begin
			v = '0;
			v.uart_mode = (k > 3);
			if (k > 3) begin
				v.uart_evt[k-4] = 1'b1;
			end else begin
				v.sync_evt[k] = 1'b1;
			end
			pulse(v);
			repeat (2) @(posedge clk);
			rd8("serial_flag", OFS_CTRL1, 8'h10);
			wr(OFS_CTRL1, 8'h00);
		end
		// Wake on a rising flag only
		sleep <= 1'b1;
		n0 = n_wake;
		v = '0;
		v.touch_ovf = 1'b1;
		v.eeprom_done = 1'b1;
		v.tick_ovf = 2'h3;
		pulse(v);
		repeat (3) @(posedge clk);
		chk("wake_rise", 32'(n0 + 1), 32'(n_wake));
		rd8("hw_flags", OFS_CTRL1, 8'he0);
		pulse(v);
		repeat (3) @(posedge clk);
		chk("wake_set", 32'(n0 + 1), 32'(n_wake));
		final_report();
	end
endmodule
